// file: design/imoc_pkg.sv
// Shared constants for the interrupt mask and overcurrent capture block
package imoc_pkg;

	// Register port geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int VAL_W  = 24;
	localparam int EVT_W  = 20;
	localparam int OC_CH  = 2;

	// Register offsets, one word per printed offset
	localparam logic [ADDR_W-1:0] ADDR_STATUS    = 16'h0403;
	localparam logic [ADDR_W-1:0] ADDR_MASK      = 16'h0405;
	localparam logic [ADDR_W-1:0] ADDR_OC_THRESH = 16'h0409;
	localparam logic [ADDR_W-1:0] ADDR_OC_CAP_A  = 16'h040a;
	localparam logic [ADDR_W-1:0] ADDR_OC_CAP_B  = 16'h040b;
	localparam logic [ADDR_W-1:0] ADDR_CFG_THREE = 16'h04f0;

	// Event bit positions shared by status and mask
	localparam int BIT_ZX_CUR_A   = 19;
	localparam int BIT_ZX_VOLT    = 17;
	localparam int BIT_NL_FVAR    = 15;
	localparam int BIT_NL_VA      = 14;
	localparam int BIT_NL_WATT    = 13;
	localparam int BIT_TEMP       = 12;
	localparam int BIT_FAST_RMS   = 11;
	localparam int BIT_PWR        = 10;
	localparam int BIT_WAVE       = 9;
	localparam int BIT_EGY        = 8;
	localparam int BIT_PULSE_TWO  = 7;
	localparam int BIT_PULSE_ONE  = 6;
	localparam int BIT_PSIGN_TWO  = 5;
	localparam int BIT_PSIGN_ONE  = 4;
	localparam int BIT_REACT_SIGN = 2;
	localparam int BIT_ACT_SIGN   = 0;

	// Implemented event bits; reserved positions stay zero
	localparam logic [EVT_W-1:0] EVT_IMPL = 20'hafff5;

	// Overcurrent enable bits in the configuration word
	localparam int OC_A_EN_BIT = 0;
	localparam int OC_B_EN_BIT = 1;

	// Reset values
	localparam logic [EVT_W-1:0] STATUS_RST = 20'h00000;
	localparam logic [EVT_W-1:0] MASK_RST   = 20'h00000;
	localparam logic [VAL_W-1:0] THRESH_RST = 24'hffffff;
	localparam logic [VAL_W-1:0] CAP_RST    = 24'h000000;
	localparam logic [OC_CH-1:0] OC_EN_RST  = 2'h0;

	// Capture channel state
	typedef struct packed {
		logic [VAL_W-1:0] value;
	} imoc_oc_state_t;

endpackage

// file: design/imoc_oc_channel.sv
// One overcurrent capture channel: compare fast rms and hold the excess
`timescale 1ns/100ps
module imoc_oc_channel (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	// Metrology side
	input  wire logic                     rms_update,
	input  wire logic [imoc_pkg::VAL_W-1:0] fast_rms,
	// Configuration
	input  wire logic                     enable,
	input  wire logic [imoc_pkg::VAL_W-1:0] threshold,
	// Held value
	output logic      [imoc_pkg::VAL_W-1:0] capture
);

	imoc_pkg::imoc_oc_state_t s;
	imoc_pkg::imoc_oc_state_t next_s;

	// Compare only on a fresh result, so a stale value is never recaught
	always_comb begin
		next_s = s;
		if (rms_update && enable && (fast_rms > threshold)) begin
			next_s.value = fast_rms;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s.value <= imoc_pkg::CAP_RST;
		end else begin
			s <= next_s;
		end
	end

	assign capture = s.value;

endmodule

// file: design/imoc_top.sv
// Interrupt mask, sticky event status and overcurrent capture registers
`timescale 1ns/100ps

module imoc_top (
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	// Register port from the serial front end
	input  wire logic [imoc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [imoc_pkg::DATA_W-1:0] reg_wdata,
	output logic      [imoc_pkg::DATA_W-1:0] reg_rdata,
	output logic                             reg_ack,
	// Metrology event pulses
	input  wire logic                        zero_cross_cur_a,
	input  wire logic                        zero_cross_volt,
	input  wire logic                        temp_ready,
	input  wire logic                        fast_rms_update,
	input  wire logic                        power_ready,
	input  wire logic                        waveform_ready,
	input  wire logic                        energy_ready,
	// Metrology levels
	input  wire logic                        noload_fund_reactive,
	input  wire logic                        noload_apparent,
	input  wire logic                        noload_active,
	input  wire logic                        reactive_power_negative,
	input  wire logic                        active_power_negative,
	// Pulse outputs and the sign of each pulse
	input  wire logic                        pulse_out_one,
	input  wire logic                        pulse_out_two,
	input  wire logic                        pulse_one_negative,
	input  wire logic                        pulse_two_negative,
	// Fast rms results
	input  wire logic [imoc_pkg::VAL_W-1:0]  fast_rms_current_a,
	input  wire logic [imoc_pkg::VAL_W-1:0]  fast_rms_current_b,
	// Host interrupt, active low
	output logic                             irq_n
);

	// Whole block state in one word
	typedef struct packed {
		// Host-visible registers
		logic [imoc_pkg::EVT_W-1:0]  status;
		logic [imoc_pkg::EVT_W-1:0]  mask;
		logic [imoc_pkg::VAL_W-1:0]  thresh;
		logic [imoc_pkg::OC_CH-1:0]  oc_en;
		// Edge and sign history
		logic [2:0]                  noload_q;
		logic [1:0]                  pulse_q;
		logic [1:0]                  psign_last;
		logic [1:0]                  psign_seen;
		logic                        react_last;
		logic                        act_last;
		logic                        pwr_seen;
		// Host answer and interrupt line
		logic [imoc_pkg::DATA_W-1:0] rdata;
		logic                        ack;
		logic                        irq;
	} imoc_top_state_t;

	imoc_top_state_t s;
	imoc_top_state_t next_s;

	// Per-channel wiring for the capture units
	logic [imoc_pkg::OC_CH-1:0][imoc_pkg::VAL_W-1:0] rms_bus;
	logic [imoc_pkg::OC_CH-1:0][imoc_pkg::VAL_W-1:0] cap_bus;

	// Combinational helpers
	logic [imoc_pkg::EVT_W-1:0] set_vec;
	logic [imoc_pkg::EVT_W-1:0] clr_vec;
	logic [imoc_pkg::EVT_W-1:0] next_status;
	logic [2:0]                 noload_now;
	logic [2:0]                 noload_chg;
	logic [1:0]                 pulse_now;
	logic [1:0]                 pulse_fall;
	logic [1:0]                 psign_now;
	logic [1:0]                 psign_flip;
	logic                       react_flip;
	logic                       act_flip;
	logic [imoc_pkg::DATA_W-1:0] rd_mux;
	// Host write results and the enabled pending events
	logic [imoc_pkg::EVT_W-1:0] next_mask;
	logic [imoc_pkg::VAL_W-1:0] next_thresh;
	logic [imoc_pkg::OC_CH-1:0] next_oc_en;
	logic [imoc_pkg::EVT_W-1:0] pend_vec;

	// Channel A first, then channel B
	assign rms_bus[0] = fast_rms_current_a;
	assign rms_bus[1] = fast_rms_current_b;

	// One capture unit per current channel
	genvar ch;
	generate
		for (ch = 0; ch < imoc_pkg::OC_CH; ch++) begin : g_oc
			imoc_oc_channel u_oc (
				.core_clk   (core_clk),
				.rst_n      (rst_n),
				.rms_update (fast_rms_update),
				.fast_rms   (rms_bus[ch]),
				.enable     (s.oc_en[ch]),
				.threshold  (s.thresh),
				.capture    (cap_bus[ch])
			);
		end
	endgenerate

	// Level and edge detection on metrology signals
	always_comb begin
		noload_now = {noload_fund_reactive, noload_apparent, noload_active};
		// Either direction of a no-load change counts
		noload_chg = noload_now ^ s.noload_q;
		pulse_now  = {pulse_out_two, pulse_out_one};
		// A pulse is issued on the high to low transition
		pulse_fall = s.pulse_q & ~pulse_now;
		psign_now  = {pulse_two_negative, pulse_one_negative};
		// First pulse has no predecessor, so no flip is reported
		psign_flip = pulse_fall & s.psign_seen
			& (psign_now ^ s.psign_last);
		// Power signs only compare across two refreshes
		react_flip = power_ready && s.pwr_seen
			&& (reactive_power_negative != s.react_last);
		act_flip   = power_ready && s.pwr_seen
			&& (active_power_negative != s.act_last);
	end

	// Gather all events into the status set vector
	always_comb begin
		set_vec = '0;
		set_vec[imoc_pkg::BIT_ZX_CUR_A]   = zero_cross_cur_a;
		set_vec[imoc_pkg::BIT_ZX_VOLT]    = zero_cross_volt;
		set_vec[imoc_pkg::BIT_NL_FVAR]    = noload_chg[2];
		set_vec[imoc_pkg::BIT_NL_VA]      = noload_chg[1];
		set_vec[imoc_pkg::BIT_NL_WATT]    = noload_chg[0];
		// Ready strobes pass straight through
		set_vec[imoc_pkg::BIT_TEMP]       = temp_ready;
		set_vec[imoc_pkg::BIT_FAST_RMS]   = fast_rms_update;
		set_vec[imoc_pkg::BIT_PWR]        = power_ready;
		set_vec[imoc_pkg::BIT_WAVE]       = waveform_ready;
		set_vec[imoc_pkg::BIT_EGY]        = energy_ready;
		// Edge and sign events from the pulse pins and the power signs
		set_vec[imoc_pkg::BIT_PULSE_TWO]  = pulse_fall[1];
		set_vec[imoc_pkg::BIT_PULSE_ONE]  = pulse_fall[0];
		set_vec[imoc_pkg::BIT_PSIGN_TWO]  = psign_flip[1];
		set_vec[imoc_pkg::BIT_PSIGN_ONE]  = psign_flip[0];
		set_vec[imoc_pkg::BIT_REACT_SIGN] = react_flip;
		set_vec[imoc_pkg::BIT_ACT_SIGN]   = act_flip;
	end

	// Host writes; reserved bits are dropped on entry
	// Read-only and unmapped offsets fall through untouched
	always_comb begin
		clr_vec     = '0;
		next_mask   = s.mask;
		next_thresh = s.thresh;
		next_oc_en  = s.oc_en;
		if (reg_wr) begin
			case (reg_addr)
				imoc_pkg::ADDR_STATUS: begin
					clr_vec = reg_wdata[imoc_pkg::EVT_W-1:0];
				end
				imoc_pkg::ADDR_MASK: begin
					next_mask = reg_wdata[imoc_pkg::EVT_W-1:0]
						& imoc_pkg::EVT_IMPL;
				end
				imoc_pkg::ADDR_OC_THRESH: begin
					next_thresh = reg_wdata[imoc_pkg::VAL_W-1:0];
				end
				imoc_pkg::ADDR_CFG_THREE: begin
					next_oc_en[0] = reg_wdata[imoc_pkg::OC_A_EN_BIT];
					next_oc_en[1] = reg_wdata[imoc_pkg::OC_B_EN_BIT];
				end
				default: begin
					clr_vec = '0;
				end
			endcase
		end
	end

	// Write-one-to-clear; a same-cycle event beats the clear
	always_comb begin
		next_status = ((s.status & ~clr_vec) | set_vec)
			& imoc_pkg::EVT_IMPL;
	end

	// Enabled pending events, one gate per status bit
	genvar b;
	generate
		for (b = 0; b < imoc_pkg::EVT_W; b++) begin : g_pend
			// Reserved bits are already zero in both words
			assign pend_vec[b] = next_status[b] & next_mask[b];
		end
	endgenerate

	// Read data selection; unmapped offsets read as zero
	always_comb begin
		rd_mux = '0;
		// Status and mask share one bit layout
		case (reg_addr)
			imoc_pkg::ADDR_STATUS: begin
				rd_mux[imoc_pkg::EVT_W-1:0] = s.status;
			end
			imoc_pkg::ADDR_MASK: begin
				rd_mux[imoc_pkg::EVT_W-1:0] = s.mask;
			end
			imoc_pkg::ADDR_OC_THRESH: begin
				rd_mux[imoc_pkg::VAL_W-1:0] = s.thresh;
			end
			imoc_pkg::ADDR_OC_CAP_A: begin
				rd_mux[imoc_pkg::VAL_W-1:0] = cap_bus[0];
			end
			imoc_pkg::ADDR_OC_CAP_B: begin
				rd_mux[imoc_pkg::VAL_W-1:0] = cap_bus[1];
			end
			imoc_pkg::ADDR_CFG_THREE: begin
				rd_mux[imoc_pkg::OC_CH-1:0] = s.oc_en;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// Next state of the whole block
	always_comb begin
		next_s = s;
		next_s.status   = next_status;
		// Edge history follows the pins every cycle
		next_s.noload_q = noload_now;
		next_s.pulse_q  = pulse_now;
		// Remember each pulse sign for the next comparison
		for (int i = 0; i < 2; i++) begin
			if (pulse_fall[i]) begin
				next_s.psign_last[i] = psign_now[i];
				next_s.psign_seen[i] = 1'b1;
			end
		end
		// Power signs are only meaningful at a power refresh
		if (power_ready) begin
			next_s.react_last = reactive_power_negative;
			next_s.act_last   = active_power_negative;
			next_s.pwr_seen   = 1'b1;
		end
		// Host-written registers
		next_s.mask   = next_mask;
		next_s.thresh = next_thresh;
		next_s.oc_en  = next_oc_en;
		// Read answer lands one cycle after the request
		next_s.ack = reg_rd || reg_wr;
		if (reg_rd) begin
			next_s.rdata = rd_mux;
		end
		// Interrupt follows the post-update status and mask
		next_s.irq = |pend_vec;
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// Host-visible registers
			s.status     <= imoc_pkg::STATUS_RST;
			s.mask       <= imoc_pkg::MASK_RST;
			s.thresh     <= imoc_pkg::THRESH_RST;
			s.oc_en      <= imoc_pkg::OC_EN_RST;
			// No history, so no pulse or sign edge on the first cycle; a no-load level already high reads as a change
			s.noload_q   <= 3'h0;
			s.pulse_q    <= 2'h0;
			s.psign_last <= 2'h0;
			s.psign_seen <= 2'h0;
			s.react_last <= 1'b0;
			s.act_last   <= 1'b0;
			s.pwr_seen   <= 1'b0;
			// Quiet bus answer and line
			s.rdata      <= 32'h0;
			s.ack        <= 1'b0;
			s.irq        <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	// The line only inverts a flop, so it never glitches
	assign reg_rdata = s.rdata;
	assign reg_ack   = s.ack;
	assign irq_n     = ~s.irq;

endmodule

// file: verification/imoc_monitor.sv
// Checker for register answers, event interrupts and read data hold
`timescale 1ns/100ps
module imoc_monitor (
	// Clock and reset
	input wire logic                        core_clk,
	input wire logic                        rst_n,
	// Register port
	input wire logic [imoc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic                        reg_wr,
	input wire logic                        reg_rd,
	input wire logic [imoc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [imoc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                        reg_ack,
	// Event sources and interrupt
	input wire logic                        zero_cross_cur_a,
	input wire logic                        fast_rms_update,
	input wire logic                        noload_active,
	input wire logic                        pulse_out_one,
	input wire logic                        irq_n
);
	logic [19:0] m;
	logic        mw;

	// Mask shadow, since the mask itself is not a port
	assign mw = reg_wr && reg_addr == imoc_pkg::ADDR_MASK;
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			m <= '0;
		else if (mw)
			m <= reg_wdata[19:0];
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	ack_after_req_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
		else $error("access not acknowledged");
	no_stray_ack_a: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
		else $error("acknowledge without access");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	zx_irq_a: assert property (zero_cross_cur_a && m[19] && !mw |=> !irq_n)
		else $error("zero crossing gave no interrupt");
	pulse_irq_a: assert property ($fell(pulse_out_one) && m[6] && !mw |=> !irq_n)
		else $error("pulse gave no interrupt");
	noload_irq_a: assert property ($changed(noload_active) && m[13] && !mw |=> !irq_n)
		else $error("no-load change gave no interrupt");
	rms_irq_a: assert property (fast_rms_update && m[11] && !mw |=> !irq_n)
		else $error("rms refresh gave no interrupt");
	irq_quiet_a: assert property (m == '0 && !mw |=> irq_n)
		else $error("interrupt with every enable clear");
	irq_sticky_a: assert property (!irq_n && !reg_wr |=> !irq_n)
		else $error("interrupt dropped without a write");

	// Main scenarios reached
	cover property (!irq_n);
	cover property (reg_rd && reg_addr == imoc_pkg::ADDR_OC_CAP_A);
	cover property ($fell(pulse_out_one) && m[6]);
endmodule

bind imoc_top imoc_monitor imoc_monitor_i (.core_clk, .rst_n, .reg_addr,
	.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .zero_cross_cur_a,
	.fast_rms_update, .noload_active, .pulse_out_one, .irq_n);

// file: verification/imoc_host_model.sv
// Host model: single word reads and writes on the register port
`timescale 1ns/100ps
module imoc_host_model (
	// Clock
	input  wire logic                        core_clk,
	// Register port
	output logic      [imoc_pkg::ADDR_W-1:0] reg_addr,
	output logic                             reg_wr,
	output logic                             reg_rd,
	output logic      [imoc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic [imoc_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        reg_ack
);
	logic [31:0] rq;
	logic        rok;

	// Idle port at time zero
	initial begin
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = '0;
	end

	// One-cycle strobe; address and data held to the answer edge
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge core_clk);
		ok = reg_ack;
		q = reg_rdata;
		// Scrambled afterwards so nothing leans on stale values
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// Status bits go away only by writing ones back
	task automatic clear(input logic [31:0] e);
		xfer(1'b1, imoc_pkg::ADDR_STATUS, e, rq, rok);
	endtask
endmodule

// file: verification/imoc_top_tb.sv
// Self-checking bench for the mask, status and overcurrent block
`timescale 1ns/100ps
module imoc_top_tb;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] reg_addr;
	logic        reg_wr, reg_rd, reg_ack, irq_n, ok;
	logic [31:0] reg_wdata, reg_rdata, q;
	logic [6:0]  ev = '0;
	logic [2:0]  nl = '0;
	logic [1:0]  ps = '0, pn = '0, po = 2'h3;
	logic [23:0] ra = '0, rb = '0;
	int          err_total = 0, compares = 0, cyc = 0;

	always #12.5 core_clk = ~core_clk;

	imoc_host_model host_i (.core_clk, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .reg_ack);
	imoc_top imoc_top_i (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .reg_ack, .irq_n,
		.zero_cross_cur_a(ev[0]), .zero_cross_volt(ev[1]),
		.temp_ready(ev[2]), .fast_rms_update(ev[3]), .power_ready(ev[4]),
		.waveform_ready(ev[5]), .energy_ready(ev[6]),
		.noload_fund_reactive(nl[0]), .noload_apparent(nl[1]),
		.noload_active(nl[2]), .reactive_power_negative(ps[1]),
		.active_power_negative(ps[0]), .pulse_out_one(po[0]),
		.pulse_out_two(po[1]), .pulse_one_negative(pn[0]),
		.pulse_two_negative(pn[1]), .fast_rms_current_a(ra),
		.fast_rms_current_b(rb));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		host_i.xfer(1'b0, a, 32'h0, q, ok);
		chk({31'h0, ok}, 32'h1);
		chk(q, e);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		host_i.xfer(1'b1, a, d, q, ok);
		chk({31'h0, ok}, 32'h1);
	endtask
	// Status must read e with the line low, then clear fully
	task automatic evt(input logic [31:0] e);
		rd(imoc_pkg::ADDR_STATUS, e);
		chk({31'h0, irq_n}, 32'h0);
		host_i.clear(e);
		rd(imoc_pkg::ADDR_STATUS, 32'h0);
		chk({31'h0, irq_n}, 32'h1);
	endtask
	task automatic pulse(input int i);
		@(posedge core_clk) ev[i] <= 1'b1;
		@(posedge core_clk) ev[i] <= 1'b0;
	endtask
	task automatic upd(input logic [23:0] a, input logic [23:0] b);
		@(posedge core_clk) ra <= a;
		rb <= b;
		pulse(3);
	endtask

	// Reset values, reserved bits, read-only and unmapped places
	task automatic t_regs();
		rd(imoc_pkg::ADDR_OC_THRESH, 32'hffffff);
		rd(imoc_pkg::ADDR_MASK, 32'h0);
		rd(imoc_pkg::ADDR_OC_CAP_A, 32'h0);
		rd(imoc_pkg::ADDR_OC_CAP_B, 32'h0);
		rd(16'h0404, 32'h0);
		wr(imoc_pkg::ADDR_OC_CAP_A, 32'h123);
		rd(imoc_pkg::ADDR_OC_CAP_A, 32'h0);
		wr(imoc_pkg::ADDR_MASK, 32'hffffffff);
		rd(imoc_pkg::ADDR_MASK, 32'h000afff5);
	endtask
	// Every event source, one at a time except that each sign flip comes with its pulse or power refresh and the two power signs flip together
	task automatic t_events();
		int b[7] = '{19, 17, 12, 11, 10, 9, 8};
		for (int i = 0; i < 7; i++) begin
			pulse(i);
			evt(32'h1 << b[i]);
		end
		for (int j = 0; j < 3; j++) begin
			@(posedge core_clk) nl[j] <= 1'b1;
			evt(32'h8000 >> j);
			@(posedge core_clk) nl[j] <= 1'b0;
			evt(32'h8000 >> j);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk) po[k] <= 1'b0;
			evt(32'h40 << k);
			@(posedge core_clk) po[k] <= 1'b1;
			pn[k] <= 1'b1;
			@(posedge core_clk) po[k] <= 1'b0;
			evt(32'h50 << k);
			@(posedge core_clk) po[k] <= 1'b1;
		end
		@(posedge core_clk) ps <= 2'h3;
		pulse(4);
		evt(32'h405);
	endtask
	// Masked events latch but leave the line quiet
	task automatic t_gate();
		wr(imoc_pkg::ADDR_MASK, 32'h0);
		pulse(2);
		@(posedge core_clk);
		chk({31'h0, irq_n}, 32'h1);
		rd(imoc_pkg::ADDR_STATUS, 32'h1000);
		wr(imoc_pkg::ADDR_MASK, 32'h1000);
		chk({31'h0, irq_n}, 32'h0);
		host_i.clear(32'h1000);
		chk({31'h0, irq_n}, 32'h1);
	endtask
	// Strict unsigned compare, per channel enable
	task automatic t_oc();
		wr(imoc_pkg::ADDR_CFG_THREE, 32'h3);
		wr(imoc_pkg::ADDR_OC_THRESH, 32'hab800000);
		rd(imoc_pkg::ADDR_OC_THRESH, 32'h800000);
		upd(24'h800000, 24'h7fffff);
		rd(imoc_pkg::ADDR_OC_CAP_A, 32'h0);
		rd(imoc_pkg::ADDR_OC_CAP_B, 32'h0);
		upd(24'h800001, 24'hffffff);
		rd(imoc_pkg::ADDR_OC_CAP_A, 32'h800001);
		rd(imoc_pkg::ADDR_OC_CAP_B, 32'hffffff);
		wr(imoc_pkg::ADDR_CFG_THREE, 32'h2);
		upd(24'h900000, 24'h900000);
		rd(imoc_pkg::ADDR_OC_CAP_A, 32'h800001);
		rd(imoc_pkg::ADDR_OC_CAP_B, 32'h900000);
		// A new value with no refresh strobe must not be caught
		@(posedge core_clk) rb <= 24'hfffffe;
		rd(imoc_pkg::ADDR_OC_CAP_B, 32'h900000);
	endtask

	task automatic summarize();
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles needed
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end

	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_events();
		t_gate();
		t_oc();
		summarize();
	end
endmodule
